// >>> uets_params.svh
`ifndef UETS_PARAMS_SVH
`define UETS_PARAMS_SVH
`define UETS_ADDR_STATUS   4'h0
`define UETS_ADDR_CONTROL  4'h4
`define UETS_ADDR_EVENT    4'h8
`define UETS_BIT_OUT       0
`define UETS_BIT_IN        1
`define UETS_BIT_SETUP     2
`define UETS_BIT_TOGGLE    3
`define UETS_BIT_ENABLE    0
`define UETS_EP0_NUM       4'h0
`define UETS_STATUS_RESET  8'h00
`define UETS_CONTROL_RESET 1'b1
`define UETS_RESP_OKAY     2'h0
`define UETS_RESP_SLVERR   2'h2
`endif

// >>> uets_pkg.sv
package uets_pkg;
  typedef enum logic [1:0] {
    UETS_TOK_OUT   = 2'h0,
    UETS_TOK_IN    = 2'h1,
    UETS_TOK_SETUP = 2'h2,
    UETS_TOK_DATA  = 2'h3
  } uets_token_type;
endpackage

// >>> uets_token_sync.sv
`include "uets_params.svh"
// two-stage synchroniser plus edge-to-pulse for the token strobe
module uets_token_sync
  import uets_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         strobe_in,
  input  wire logic [W-1:0] data_in,
  output logic              pulse_out,
  output logic [W-1:0]      data_out
);
  logic         s1_q;
  logic         s2_q;
  logic         s3_q;
  logic [W-1:0] d1_q;
  logic [W-1:0] d2_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      d1_q <= '0;
      d2_q <= '0;
    end else begin
      s1_q <= strobe_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      d1_q <= data_in;
      d2_q <= d1_q;
    end
  end

  assign pulse_out = s2_q & ~s3_q;
  assign data_out  = d2_q;
endmodule

// >>> uets_axil_slave.sv
`include "uets_params.svh"
// single-outstanding axi4-lite slave; register core sees one-cycle strobes
module uets_axil_slave
  import uets_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_stb,
  output logic [3:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic             rd_stb,
  output logic [3:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  logic        aw_have_q;
  logic        w_have_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign wr_stb  = aw_have_q & w_have_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 4'h0;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UETS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_stb) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? `UETS_RESP_SLVERR : `UETS_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_stb  = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `UETS_RESP_OKAY;
    end else if (rd_stb) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_err ? `UETS_RESP_SLVERR : `UETS_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> uets_ep0_status.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`include "uets_params.svh"
// Overview of operation
// - status bit 3 shows the toggle of the last data packet received on endpoint 0, read only.
// - a setup token to endpoint 0 sets the setup flag in status bit 2.
// - the setup flag survives later in and out tokens and clears only by a software write or reset.
// - an in token sets status bit 1, a setup or out token clears it, and software only reads it.
// - an out token sets status bit 0, a setup or in token clears it.
// - turning the function enable off and on again clears the toggle, in and out flags.
// - only traffic addressed to endpoint 0 changes these flags.
module uets_ep0_status
  import uets_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        tok_strobe,
  input  wire logic [1:0]  tok_type,
  input  wire logic [3:0]  tok_endp,
  input  wire logic        tok_data1,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             usb_function_enable
);
  logic        ev_pulse;
  logic [6:0]  ev_word;
  logic [1:0]  ev_type;
  logic [3:0]  ev_endp;
  logic        ev_d1;
  logic        wr_stb;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_stb;
  logic [3:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  logic        toggle_q;
  logic        setup_q;
  logic        in_q;
  logic        out_q;
  logic        enable_q;
  logic        reenable;
  logic        ep0_hit;
  logic        setup_clr;
  logic [7:0]  ep0_token_status;
  logic [7:0]  event_count_q;

  localparam logic [7:0] STATUS_RST = `UETS_STATUS_RESET;

  // one-cycle write strobe aimed at one register, low byte enabled
  function automatic logic wr_hit(input logic       stb,
                                  input logic [3:0] adr,
                                  input logic [3:0] strb,
                                  input logic [3:0] a);
    return stb && (adr == a) && strb[0];
  endfunction

  function automatic logic addr_known(input logic [3:0] a);
    return (a == `UETS_ADDR_STATUS) || (a == `UETS_ADDR_CONTROL) || (a == `UETS_ADDR_EVENT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  uets_token_sync #(
    .W (7)
  ) u_sync (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .strobe_in (tok_strobe),
    .data_in   ({tok_type, tok_endp, tok_data1}),
    .pulse_out (ev_pulse),
    .data_out  (ev_word)
  );

  assign ev_type = ev_word[6:5];
  assign ev_endp = ev_word[4:1];
  assign ev_d1   = ev_word[0];
  assign ep0_hit = ev_pulse && (ev_endp == `UETS_EP0_NUM);

  uets_axil_slave u_bus (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_stb        (rd_stb),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  assign wr_err = ~addr_known(wr_addr);
  assign rd_err = ~addr_known(rd_addr);

  ////////////////////////////////////////////////////////////////////////
  // function enable; off-then-on edge clears the in, out and toggle flags, not the setup flag
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      enable_q <= `UETS_CONTROL_RESET;
    end else if (wr_hit(wr_stb, wr_addr, wr_strb, `UETS_ADDR_CONTROL)) begin
      enable_q <= wr_data[`UETS_BIT_ENABLE];
    end
  end

  assign reenable = wr_hit(wr_stb, wr_addr, wr_strb, `UETS_ADDR_CONTROL)
                    && !enable_q && wr_data[`UETS_BIT_ENABLE];
  assign usb_function_enable = enable_q;

  ////////////////////////////////////////////////////////////////////////
  // setup flag: write 0 to bit 2 clears; a same-cycle endpoint 0 setup token wins
  assign setup_clr = wr_hit(wr_stb, wr_addr, wr_strb, `UETS_ADDR_STATUS)
                     && !wr_data[`UETS_BIT_SETUP];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      setup_q <= STATUS_RST[`UETS_BIT_SETUP];
    end else if (ep0_hit && ev_type == UETS_TOK_SETUP) begin
      setup_q <= 1'b1;
    end else if (setup_clr) begin
      setup_q <= 1'b0;
    end
  end

  // in/out flags and received toggle; hardware only, software cannot write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      in_q  <= STATUS_RST[`UETS_BIT_IN];
      out_q <= STATUS_RST[`UETS_BIT_OUT];
    end else if (ep0_hit && ev_type != UETS_TOK_DATA) begin
      in_q  <= (ev_type == UETS_TOK_IN);
      out_q <= (ev_type == UETS_TOK_OUT);
    end else if (reenable) begin
      in_q  <= 1'b0;
      out_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_q <= STATUS_RST[`UETS_BIT_TOGGLE];
    end else if (ep0_hit && ev_type == UETS_TOK_DATA) begin
      toggle_q <= ev_d1;
    end else if (reenable) begin
      toggle_q <= 1'b0;
    end
  end

  // count of endpoint 0 events, wraps
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      event_count_q <= 8'h00;
    end else if (ep0_hit) begin
      event_count_q <= event_count_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ep0_token_status = 8'h00;
    ep0_token_status[`UETS_BIT_TOGGLE] = toggle_q;
    ep0_token_status[`UETS_BIT_SETUP]  = setup_q;
    ep0_token_status[`UETS_BIT_IN]     = in_q;
    ep0_token_status[`UETS_BIT_OUT]    = out_q;
  end

  always_comb begin
    case (rd_addr)
      `UETS_ADDR_STATUS:  rd_data = {24'h0, ep0_token_status};
      `UETS_ADDR_CONTROL: rd_data = {31'h0, enable_q};
      `UETS_ADDR_EVENT:   rd_data = {24'h0, event_count_q};
      default:            rd_data = 32'h0;
    endcase
  end
endmodule

// >>> uets_ep0_asserts.sv
`include "uets_params.svh"
module uets_ep0_asserts (
  input logic        clk_sys,
  input logic        sys_rst,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [3:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        usb_function_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [3:0] ra_q;
  wire        mapped = ra_q == `UETS_ADDR_STATUS || ra_q == `UETS_ADDR_CONTROL || ra_q == `UETS_ADDR_EVENT;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) ra_q <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  ////////////////////////////////////////////////////////////
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_wr_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_rsvd_zero: assert property (s_axi_rvalid && ra_q == `UETS_ADDR_STATUS |-> s_axi_rdata[31:4] == 28'h0)
    else $error("reserved status bits set");
  a_flag_excl: assert property (s_axi_rvalid && ra_q == `UETS_ADDR_STATUS |-> s_axi_rdata[1:0] != 2'h3)
    else $error("in and out flags both set");
  a_unmap_err: assert property (s_axi_rvalid && !mapped |-> s_axi_rresp == `UETS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_ctl_read: assert property (s_axi_rvalid && ra_q == `UETS_ADDR_CONTROL |-> s_axi_rdata[0] == usb_function_enable)
    else $error("control read differs from enable");
endmodule
bind uets_ep0_status uets_ep0_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .usb_function_enable(usb_function_enable));

// >>> uets_usb_host_model.sv
module uets_usb_host_model (
  input  logic       clk_sys,
  output logic       tok_strobe,
  output logic [1:0] tok_type,
  output logic [3:0] tok_endp,
  output logic       tok_data1
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tok_strobe = 1'b0;
    tok_type   = 2'h0;
    tok_endp   = 4'hF;
    tok_data1  = 1'b0;
  end
  // fields settle before the strobe, then scramble once it is over
  task automatic send(input logic [1:0] t, input logic [3:0] e, input logic d, input int gap);
    @(posedge clk_sys);
    tok_type <= t;
    tok_endp <= e;
    tok_data1 <= d;
    repeat (4) @(posedge clk_sys);
    tok_strobe <= 1'b1;
    repeat (3) @(posedge clk_sys);
    tok_strobe <= 1'b0;
    @(posedge clk_sys);
    tok_type <= ~t;
    tok_endp <= ~e;
    tok_data1 <= ~d;
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule

// >>> usb_ep0_token_status_tb.sv
`include "uets_params.svh"
module usb_ep0_token_status_tb
  import uets_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, sys_rst = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, st;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, en, tok_strobe, tok_data1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tok_type, bexp, bq[$];
  logic [3:0]  tok_endp;
  logic [31:0] s_axi_rdata;
  logic [34:0] rq[$];
  logic [7:0]  ev_cnt = 8'h00;
  int          n_mismatch = 0, checked = 0;
  `define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, s); end end
  always #50 clk_sys = ~clk_sys;
  uets_ep0_status DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .tok_strobe(tok_strobe), .tok_type(tok_type),
    .tok_endp(tok_endp), .tok_data1(tok_data1), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .usb_function_enable(en));
  uets_usb_host_model host (.clk_sys(clk_sys), .tok_strobe(tok_strobe), .tok_type(tok_type), .tok_endp(tok_endp),
    .tok_data1(tok_data1));
  ////////////////////////////////////////////////////////////
  // handshakes are judged at the settled negedge, acted on at the next posedge
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, tb;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end while (!tb);
    @(posedge clk_sys);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tr;
    rq.push_back({a == `UETS_ADDR_CONTROL, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end while (!tr);
    @(posedge clk_sys);
  endtask
  task automatic tok(input logic [1:0] t, input logic [3:0] e, input logic d);
    host.send(t, e, d, $urandom_range(0, 4));
    if (e == 4'h0) begin
      ev_cnt++;
      case (t)
        UETS_TOK_OUT:   st[1:0] = 2'b01;
        UETS_TOK_IN:    st[1:0] = 2'b10;
        UETS_TOK_SETUP: st[2:0] = 3'b100;
        default:        st[3] = d;
      endcase
    end
    axr(`UETS_ADDR_STATUS, {28'h0, st}, `UETS_RESP_OKAY);
  endtask
  task automatic summarize();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  always @(negedge clk_sys) begin
    if (!sys_rst && s_axi_rvalid && s_axi_rready) begin
      `CHK("rdata", rq[0][31:0], s_axi_rdata)
      `CHK("rresp", rq[0][33:32], s_axi_rresp)
      if (rq[0][34]) `CHK("enable", rq[0][0], en)
      void'(rq.pop_front());
    end
    if (!sys_rst && s_axi_bvalid && s_axi_bready) begin
      bexp = bq.pop_front();
      `CHK("bresp", bexp, s_axi_bresp)
    end
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(38223));
    st = 4'h0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    axr(`UETS_ADDR_STATUS, 32'h0, `UETS_RESP_OKAY);
    axr(`UETS_ADDR_CONTROL, 32'h1, `UETS_RESP_OKAY);
    axr(4'hC, 32'h0, `UETS_RESP_SLVERR);
    axw(4'hC, 32'hFFFFFFFF, `UETS_RESP_SLVERR);
    for (int i = 0; i < 24; i++) begin
      tok(2'(i < 4 ? i : $urandom), (i < 4 || $urandom_range(0, 1)) ? 4'h0 : 4'($urandom_range(1, 15)), 1'($urandom));
    end
    tok(UETS_TOK_SETUP, 4'h0, 1'b0);
    tok(UETS_TOK_DATA, 4'h0, 1'b1);
    tok(UETS_TOK_IN, 4'h0, 1'b0);
    axw(`UETS_ADDR_STATUS, 32'hFFFFFFFF, `UETS_RESP_OKAY);
    axr(`UETS_ADDR_STATUS, {28'h0, st}, `UETS_RESP_OKAY);
    axw(`UETS_ADDR_STATUS, 32'h0, `UETS_RESP_OKAY);
    st[2] = 1'b0;
    axr(`UETS_ADDR_STATUS, {28'h0, st}, `UETS_RESP_OKAY);
    tok(UETS_TOK_SETUP, 4'h0, 1'b0);
    tok(UETS_TOK_OUT, 4'h0, 1'b0);
    tok(UETS_TOK_DATA, 4'h0, 1'b1);
    axw(`UETS_ADDR_CONTROL, 32'h0, `UETS_RESP_OKAY);
    axr(`UETS_ADDR_CONTROL, 32'h0, `UETS_RESP_OKAY);
    axw(`UETS_ADDR_CONTROL, 32'h1, `UETS_RESP_OKAY);
    st = 4'b0100;
    axr(`UETS_ADDR_STATUS, {28'h0, st}, `UETS_RESP_OKAY);
    axr(`UETS_ADDR_EVENT, {24'h0, ev_cnt}, `UETS_RESP_OKAY);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    st = 4'h0;
    @(posedge clk_sys);
    axr(`UETS_ADDR_STATUS, 32'h0, `UETS_RESP_OKAY);
    summarize();
  end
endmodule
